// File: hdl/dcr_defs.svh
// Register offsets, field positions, reset values and port framing for the datapath configuration registers
// Overview of operation
// [R1] Bypass bit 7 set routes data around the constellation symbol mappers.
// [R2] Bypass bit 6 set passes samples around the root raised cosine filters.
// [R3] Each of five filter bypass bits skips its own interpolation stage independently.
// [R4] Software should bypass interpolation stages in ascending order, stage zero first.
// [R5] Roll-off codes 00,01,10,11 select 0.12, 0.18, 0.15, 0.13.
// [R6] Mapping codes 000-001 first standard, 010-110 second standard, 111 unused.
// [R7] Summed output multiplied by unsigned 2.6 gain, reset value 00001101.
// [R8] Input data multiplied by unsigned 3.5 gain, reset value 00100000 is unity.
// [R9] Input gain path replaces the mapper path whenever the mapper is bypassed.
// [R10] Oscillator 0 tuning word built from three bytes, lowest address least significant.
// [R11] Overrange samples after summed output gain are clipped and counted in eight bits.
// [R12] Reserved bits read back zero and writes to them change nothing.
`ifndef DCR_DEFS_SVH
`define DCR_DEFS_SVH

`define DCR_ADDR_CLIP_COUNT 8'h01
`define DCR_ADDR_BYPASS 8'h06
`define DCR_ADDR_SHAPE_MAP 8'h07
`define DCR_ADDR_SUM_GAIN 8'h08
`define DCR_ADDR_IN_GAIN 8'h09
`define DCR_ADDR_OSC0_LOW 8'h0A
`define DCR_ADDR_OSC0_MID 8'h0B
`define DCR_ADDR_OSC0_HIGH 8'h0C

`define DCR_BIT_MAPPER_BYPASS 7
`define DCR_BIT_RRC_BYPASS 6
`define DCR_BYPASS_MASK 8'hDF
`define DCR_SHAPE_MAP_MASK 8'h37
`define DCR_ROLLOFF_LSB 4

`define DCR_RESET_BYPASS 8'h00
`define DCR_RESET_SHAPE_MAP 8'h00
`define DCR_RESET_SUM_GAIN 8'h0D
`define DCR_RESET_IN_GAIN 8'h20
`define DCR_RESET_OSC0 24'h000000

`define DCR_SUM_GAIN_FRAC 6
`define DCR_IN_GAIN_FRAC 5

`define DCR_ROLLOFF_00 8'h78
`define DCR_ROLLOFF_01 8'hB4
`define DCR_ROLLOFF_10 8'h96
`define DCR_ROLLOFF_11 8'h82

`define DCR_INSTR_BITS 5'h10
`define DCR_INSTR_RW_BIT 15
`define DCR_MAP_UNUSED 3'h7
`define DCR_MAP_SECOND_MIN 3'h2

`endif

// File: hdl/dcr_pkg.sv
// Types shared by the datapath configuration register block
`default_nettype none
package dcr_pkg;
  typedef enum logic [1:0] {
    DCR_PORT_IDLE,
    DCR_PORT_INSTR,
    DCR_PORT_DATA
  } dcr_port_state_t;
endpackage : dcr_pkg
`default_nettype wire

// File: hdl/dcr_config_regs.sv
// Datapath configuration registers with serial configuration port, gain stages and clip counter
`timescale 1ns/1ps
`default_nettype none
`include "dcr_defs.svh"

module dcr_config_regs #(
  parameter int DATA_W = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic spi_sclk,
  input wire logic spi_csb,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  input wire logic clip_count_clear,
  input wire logic signed [DATA_W-1:0] raw_data,
  input wire logic signed [DATA_W-1:0] mapper_data,
  output logic signed [DATA_W-1:0] shaper_in_data,
  input wire logic signed [DATA_W-1:0] summed_data,
  output logic signed [DATA_W-1:0] summed_out_data,
  output logic clip_event,
  output logic mapper_bypass,
  output logic root_raised_cosine_bypass,
  output logic [4:0] interp_bypass,
  output logic [1:0] rolloff_select,
  output logic [7:0] rolloff_milli,
  output logic [2:0] constellation_select,
  output logic constellation_second_std,
  output logic constellation_unused,
  output logic [7:0] summed_output_gain,
  output logic [7:0] input_gain,
  output logic [23:0] osc0_tuning_word
);

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [7:0] path_bypass_ctrl, next_path_bypass_ctrl;
  logic [7:0] shaping_mapper_cfg, next_shaping_mapper_cfg;
  logic [7:0] next_summed_output_gain, next_input_gain;
  logic [23:0] next_osc0_tuning_word;
  logic [7:0] clip_event_count, next_clip_event_count;

  // ----------------------------------------
  // Serial port state
  // ----------------------------------------
  dcr_pkg::dcr_port_state_t state, next_state;
  logic sclk_q, next_sclk_q;
  logic [4:0] bit_count, next_bit_count;
  logic [15:0] instr_sr, next_instr_sr;
  logic [7:0] data_sr, next_data_sr;
  logic [7:0] out_sr, next_out_sr;
  logic [7:0] addr, next_addr;
  logic addr_hi, next_addr_hi;
  logic read_mode, next_read_mode;
  logic wr_en;
  logic [7:0] wr_data;
  logic sclk_rise, sclk_fall;
  logic [15:0] instr_full;

  function automatic logic [7:0] read_mux(input logic [7:0] a, input logic hi, input logic [7:0] bp,
                                          input logic [7:0] sm, input logic [7:0] sg, input logic [7:0] ig,
                                          input logic [23:0] tw, input logic [7:0] cc);
    logic [7:0] v;
    v = 8'h00;
    if (!hi) begin
      case (a)
        `DCR_ADDR_CLIP_COUNT: v = cc;
        `DCR_ADDR_BYPASS: v = bp;
        `DCR_ADDR_SHAPE_MAP: v = sm;
        `DCR_ADDR_SUM_GAIN: v = sg;
        `DCR_ADDR_IN_GAIN: v = ig;
        `DCR_ADDR_OSC0_LOW: v = tw[7:0];
        `DCR_ADDR_OSC0_MID: v = tw[15:8];
        `DCR_ADDR_OSC0_HIGH: v = tw[23:16];
        default: v = 8'h00;
      endcase
    end
    return v;
  endfunction : read_mux

  assign sclk_rise = spi_sclk & ~sclk_q;
  assign sclk_fall = ~spi_sclk & sclk_q;
  assign instr_full = {instr_sr[14:0], spi_sdi};

  always_comb begin
    next_state = state;
    next_sclk_q = spi_sclk;
    next_bit_count = bit_count;
    next_instr_sr = instr_sr;
    next_data_sr = data_sr;
    next_out_sr = out_sr;
    next_addr = addr;
    next_addr_hi = addr_hi;
    next_read_mode = read_mode;
    wr_en = 1'b0;
    wr_data = {data_sr[6:0], spi_sdi};
    if (spi_csb) begin
      // Deselect aborts any partial byte so the next frame starts clean
      next_state = dcr_pkg::DCR_PORT_IDLE;
      next_bit_count = 5'h00;
    end else begin
      case (state)
        dcr_pkg::DCR_PORT_IDLE: begin
          next_state = dcr_pkg::DCR_PORT_INSTR;
          next_bit_count = 5'h00;
          if (sclk_rise) begin
            next_instr_sr = {instr_sr[14:0], spi_sdi};
            next_bit_count = 5'h01;
          end
        end
        dcr_pkg::DCR_PORT_INSTR: begin
          if (sclk_rise) begin
            next_instr_sr = instr_full;
            next_bit_count = bit_count + 5'h01;
            if (bit_count == `DCR_INSTR_BITS - 5'h01) begin
              next_state = dcr_pkg::DCR_PORT_DATA;
              next_bit_count = 5'h00;
              next_read_mode = instr_full[`DCR_INSTR_RW_BIT];
              next_addr = instr_full[7:0];
              next_addr_hi = |instr_full[12:8];
              next_out_sr = read_mux(instr_full[7:0], |instr_full[12:8], path_bypass_ctrl, shaping_mapper_cfg,
                                     summed_output_gain, input_gain, osc0_tuning_word, clip_event_count);
            end
          end
        end
        dcr_pkg::DCR_PORT_DATA: begin
          if (sclk_rise) begin
            next_data_sr = wr_data;
            next_bit_count = bit_count + 5'h01;
            if (bit_count == 5'h07) begin
              wr_en = ~read_mode;
              next_bit_count = 5'h00;
              // Streaming continues at the next higher address
              next_addr = addr + 8'h01;
              next_addr_hi = addr_hi | (&addr);
              next_out_sr = read_mux(addr + 8'h01, addr_hi | (&addr), path_bypass_ctrl, shaping_mapper_cfg,
                                     summed_output_gain, input_gain, osc0_tuning_word, clip_event_count);
            end
          end else if (sclk_fall && bit_count != 5'h00) begin
            next_out_sr = {out_sr[6:0], 1'b0};
          end
        end
        default: next_state = dcr_pkg::DCR_PORT_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= dcr_pkg::DCR_PORT_IDLE;
      sclk_q <= 1'b0;
      bit_count <= 5'h00;
      instr_sr <= 16'h0000;
      data_sr <= 8'h00;
      out_sr <= 8'h00;
      addr <= 8'h00;
      addr_hi <= 1'b0;
      read_mode <= 1'b0;
    end else begin
      state <= next_state;
      sclk_q <= next_sclk_q;
      bit_count <= next_bit_count;
      instr_sr <= next_instr_sr;
      data_sr <= next_data_sr;
      out_sr <= next_out_sr;
      addr <= next_addr;
      addr_hi <= next_addr_hi;
      read_mode <= next_read_mode;
    end
  end

  assign spi_sdo = out_sr[7];
  assign spi_sdo_oe = ~spi_csb & read_mode & (state == dcr_pkg::DCR_PORT_DATA);

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_comb begin
    next_path_bypass_ctrl = path_bypass_ctrl;
    next_shaping_mapper_cfg = shaping_mapper_cfg;
    next_summed_output_gain = summed_output_gain;
    next_input_gain = input_gain;
    next_osc0_tuning_word = osc0_tuning_word;
    if (wr_en && !addr_hi) begin
      case (addr)
        `DCR_ADDR_BYPASS: next_path_bypass_ctrl = wr_data & `DCR_BYPASS_MASK; // [R12]
        `DCR_ADDR_SHAPE_MAP: next_shaping_mapper_cfg = wr_data & `DCR_SHAPE_MAP_MASK; // [R12]
        `DCR_ADDR_SUM_GAIN: next_summed_output_gain = wr_data;
        `DCR_ADDR_IN_GAIN: next_input_gain = wr_data;
        `DCR_ADDR_OSC0_LOW: next_osc0_tuning_word[7:0] = wr_data; // [R10]
        `DCR_ADDR_OSC0_MID: next_osc0_tuning_word[15:8] = wr_data; // [R10]
        `DCR_ADDR_OSC0_HIGH: next_osc0_tuning_word[23:16] = wr_data; // [R10]
        default: next_input_gain = input_gain;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      path_bypass_ctrl <= `DCR_RESET_BYPASS;
      shaping_mapper_cfg <= `DCR_RESET_SHAPE_MAP;
      summed_output_gain <= `DCR_RESET_SUM_GAIN; // [R7]
      input_gain <= `DCR_RESET_IN_GAIN; // [R8]
      osc0_tuning_word <= `DCR_RESET_OSC0;
    end else begin
      path_bypass_ctrl <= next_path_bypass_ctrl;
      shaping_mapper_cfg <= next_shaping_mapper_cfg;
      summed_output_gain <= next_summed_output_gain;
      input_gain <= next_input_gain;
      osc0_tuning_word <= next_osc0_tuning_word;
    end
  end

  // ----------------------------------------
  // Datapath controls
  // ----------------------------------------
  // Stage order is left to software; any bypass pattern is honoured as written
  assign mapper_bypass = path_bypass_ctrl[`DCR_BIT_MAPPER_BYPASS]; // [R1]
  assign root_raised_cosine_bypass = path_bypass_ctrl[`DCR_BIT_RRC_BYPASS]; // [R2]
  assign interp_bypass = path_bypass_ctrl[4:0]; // [R3] [R4]
  assign rolloff_select = shaping_mapper_cfg[`DCR_ROLLOFF_LSB+1:`DCR_ROLLOFF_LSB];
  assign constellation_select = shaping_mapper_cfg[2:0];
  assign constellation_unused = (constellation_select == `DCR_MAP_UNUSED); // [R6]
  assign constellation_second_std = (constellation_select >= `DCR_MAP_SECOND_MIN) & ~constellation_unused; // [R6]

  always_comb begin
    case (rolloff_select) // [R5]
      2'h0: rolloff_milli = `DCR_ROLLOFF_00;
      2'h1: rolloff_milli = `DCR_ROLLOFF_01;
      2'h2: rolloff_milli = `DCR_ROLLOFF_10;
      default: rolloff_milli = `DCR_ROLLOFF_11;
    endcase
  end

  // ----------------------------------------
  // Gain stages with clipping
  // ----------------------------------------
  logic signed [DATA_W+8:0] in_prod, sum_prod, in_scaled, sum_scaled;
  logic in_ovf, sum_ovf;
  logic signed [DATA_W-1:0] in_sat, sum_sat, next_shaper_in_data, next_summed_out_data;
  logic next_clip_event;

  always_comb begin
    in_prod = raw_data * $signed({1'b0, input_gain}); // [R8]
    in_scaled = in_prod >>> `DCR_IN_GAIN_FRAC;
    in_ovf = ~(&in_scaled[DATA_W+8:DATA_W-1]) & (|in_scaled[DATA_W+8:DATA_W-1]);
    in_sat = in_ovf ? {in_scaled[DATA_W+8], {(DATA_W-1){~in_scaled[DATA_W+8]}}} : in_scaled[DATA_W-1:0];
    next_shaper_in_data = mapper_bypass ? in_sat : mapper_data; // [R9]
    sum_prod = summed_data * $signed({1'b0, summed_output_gain}); // [R7]
    sum_scaled = sum_prod >>> `DCR_SUM_GAIN_FRAC;
    sum_ovf = ~(&sum_scaled[DATA_W+8:DATA_W-1]) & (|sum_scaled[DATA_W+8:DATA_W-1]);
    // Clip to full scale rather than wrap, which would flip the sign of the carrier
    sum_sat = sum_ovf ? {sum_scaled[DATA_W+8], {(DATA_W-1){~sum_scaled[DATA_W+8]}}} : sum_scaled[DATA_W-1:0]; // [R11]
    next_summed_out_data = sum_sat;
    next_clip_event = sum_ovf; // [R11]
    next_clip_event_count = clip_event_count;
    // Count sticks at its top value; a clip in the clear cycle is still counted
    if (clip_count_clear) begin
      next_clip_event_count = {7'h00, sum_ovf};
    end else if (sum_ovf && clip_event_count != 8'hFF) begin
      next_clip_event_count = clip_event_count + 8'h01; // [R11]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      shaper_in_data <= '0;
      summed_out_data <= '0;
      clip_event <= 1'b0;
      clip_event_count <= 8'h00;
    end else begin
      shaper_in_data <= next_shaper_in_data;
      summed_out_data <= next_summed_out_data;
      clip_event <= next_clip_event;
      clip_event_count <= next_clip_event_count;
    end
  end

endmodule : dcr_config_regs
`default_nettype wire

// File: bench/dcr_config_regs_chk.sv
// Port checker for the datapath configuration registers
`timescale 1ns/1ps
`default_nettype none
module dcr_config_regs_chk #(
  parameter int DATA_W = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic spi_csb,
  input wire logic clip_event,
  input wire logic mapper_bypass,
  input wire logic signed [DATA_W-1:0] raw_data,
  input wire logic signed [DATA_W-1:0] mapper_data,
  input wire logic signed [DATA_W-1:0] shaper_in_data,
  input wire logic signed [DATA_W-1:0] summed_data,
  input wire logic signed [DATA_W-1:0] summed_out_data,
  input wire logic [1:0] rolloff_select,
  input wire logic [7:0] rolloff_milli,
  input wire logic [2:0] constellation_select,
  input wire logic constellation_second_std,
  input wire logic constellation_unused,
  input wire logic [7:0] summed_output_gain,
  input wire logic [7:0] input_gain,
  input wire logic [23:0] osc0_tuning_word
);
  localparam longint MX = (longint'(1) <<< (DATA_W - 1)) - 1;
  // -------------------------------------------------------
  // Reference arithmetic: floor shift, then clamp
  // -------------------------------------------------------
  function automatic longint scale(input longint v, input longint g, input int sh);
    return (v * g) >>> sh;
  endfunction : scale
  function automatic bit over(input longint v);
    return v > MX || v < ~MX;
  endfunction : over
  function automatic logic [DATA_W-1:0] sat(input longint v);
    return DATA_W'((v > MX) ? MX : (v < ~MX) ? ~MX : v);
  endfunction : sat
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_overrange;
    over(scale(summed_data, summed_output_gain, 6));
  endsequence
  sequence s_in_range;
    !over(scale(summed_data, summed_output_gain, 6));
  endsequence
  a_rolloff_table: assert property (rolloff_milli == (rolloff_select == 2'h0 ? 8'h78 : rolloff_select == 2'h1 ?
    8'hB4 : rolloff_select == 2'h2 ? 8'h96 : 8'h82)) else $error("roll-off value wrong for code");
  a_second_std: assert property (constellation_second_std == (constellation_select inside {[3'h2:3'h6]}))
    else $error("second standard flag wrong");
  a_unused_code: assert property (constellation_unused == (constellation_select == 3'h7))
    else $error("unused code flag wrong");
  a_mapper_path: assert property (!mapper_bypass |=> shaper_in_data == $past(mapper_data))
    else $error("mapper data not passed");
  a_gain_path: assert property (mapper_bypass |=>
    shaper_in_data == sat(scale($past(raw_data), $past(input_gain), 5))) else $error("input gain path wrong");
  a_sum_gain: assert property (s_in_range |=> !clip_event &&
    summed_out_data == sat(scale($past(summed_data), $past(summed_output_gain), 6))) else $error("summed gain wrong");
  a_clip_flag: assert property (s_overrange |=> clip_event &&
    summed_out_data == sat(scale($past(summed_data), $past(summed_output_gain), 6))) else $error("clip not flagged");
  a_tuning_hold: assert property ($changed(osc0_tuning_word) && !$past(reset) |-> !$past(spi_csb))
    else $error("tuning word changed outside a frame");
endmodule : dcr_config_regs_chk
bind dcr_config_regs dcr_config_regs_chk #(.DATA_W(DATA_W)) u_chk (.clk, .reset, .spi_csb, .clip_event,
  .mapper_bypass, .raw_data, .mapper_data, .shaper_in_data, .summed_data, .summed_out_data, .rolloff_select,
  .rolloff_milli, .constellation_select, .constellation_second_std, .constellation_unused, .summed_output_gain,
  .input_gain, .osc0_tuning_word);
`default_nettype wire

// File: bench/dcr_config_regs_bench.sv
// Self-checking bench for the datapath configuration registers
`timescale 1ns/1ps
`default_nettype none
module dcr_config_regs_bench;
  logic clk = 0, reset = 1, spi_sclk = 0, spi_csb = 1, spi_sdi = 0, clip_count_clear = 0;
  logic [15:0] raw_data = 0, mapper_data = 0, summed_data = 0;
  wire logic spi_sdo, spi_sdo_oe, clip_event, mapper_bypass, root_raised_cosine_bypass;
  wire logic constellation_second_std, constellation_unused;
  wire logic [15:0] shaper_in_data, summed_out_data;
  wire logic [4:0] interp_bypass;
  wire logic [1:0] rolloff_select;
  wire logic [2:0] constellation_select;
  wire logic [7:0] rolloff_milli, summed_output_gain, input_gain;
  wire logic [23:0] osc0_tuning_word;
  int bad_count = 0, total_checks = 0, cycles = 0;
  dcr_config_regs #(.DATA_W(16)) u_dut (.clk, .reset, .spi_sclk, .spi_csb, .spi_sdi, .spi_sdo, .spi_sdo_oe,
    .clip_count_clear, .raw_data, .mapper_data, .shaper_in_data, .summed_data, .summed_out_data, .clip_event,
    .mapper_bypass, .root_raised_cosine_bypass, .interp_bypass, .rolloff_select, .rolloff_milli,
    .constellation_select, .constellation_second_std, .constellation_unused, .summed_output_gain, .input_gain,
    .osc0_tuning_word);
  initial forever #2 clk = ~clk;
  // Whole run needs about 5200 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      test_done();
    end
  end
  // -------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------
  task automatic test_done;
    if (bad_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Each serial level is held two cycles, as the sampled port needs
  task automatic frame(input logic rd, input logic [12:0] a, input logic [7:0] wd, output logic [7:0] q);
    logic [23:0] sh;
    sh = {rd, 2'h0, a, wd};
    spi_csb = 0;
    step(2);
    for (int i = 23; i >= 0; i--) begin
      spi_sdi = sh[i];
      spi_sclk = 0;
      step(2);
      if (i < 8) begin
        q[i] = spi_sdo;
        check(spi_sdo_oe, rd);
      end
      spi_sclk = 1;
      step(2);
    end
    spi_sclk = 0;
    step(2);
    spi_csb = 1;
    step(2);
    check(spi_sdo_oe, 1'h0);
  endtask : frame
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] q;
    frame(1'h0, a, d, q);
  endtask : wr
  task automatic rd(input logic [12:0] a, input logic [7:0] exp);
    logic [7:0] q;
    frame(1'h1, a, 8'h00, q);
    check(q, exp);
  endtask : rd
  // -------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------
  task automatic t_reset_values;
    check(summed_output_gain, 8'h0D);
    check(input_gain, 8'h20);
    rd(13'h006, 8'h00);
    rd(13'h008, 8'h0D);
    rd(13'h009, 8'h20);
    rd(13'h00C, 8'h00);
  endtask : t_reset_values
  task automatic t_bypass;
    logic [7:0] v [5] = '{8'h80, 8'h40, 8'h01, 8'h1F, 8'hFF};
    foreach (v[i]) begin
      wr(13'h006, v[i]);
      check(mapper_bypass, v[i][7]);
      check(root_raised_cosine_bypass, v[i][6]);
      check(interp_bypass, v[i][4:0]);
      rd(13'h006, v[i] & 8'hDF);
    end
    wr(13'h006, 8'h00);
  endtask : t_bypass
  task automatic t_shape;
    logic [7:0] roll [4] = '{8'h78, 8'hB4, 8'h96, 8'h82};
    for (int i = 0; i < 8; i++) begin
      wr(13'h007, {2'h3, i[1:0], 1'h1, i[2:0]});
      check(rolloff_select, i[1:0]);
      check(rolloff_milli, roll[i[1:0]]);
      check(constellation_select, i[2:0]);
      check(constellation_second_std, i >= 2 && i <= 6);
      check(constellation_unused, i == 7);
      rd(13'h007, {2'h0, i[1:0], 1'h0, i[2:0]});
    end
  endtask : t_shape
  task automatic t_datapath;
    mapper_data = 16'h5A5A;
    step(1);
    check(shaper_in_data, 16'h5A5A);
    wr(13'h006, 8'h80);
    wr(13'h009, 8'hFF);
    raw_data = 16'h0100;
    step(1);
    check(shaper_in_data, 16'h07F8);
    raw_data = 16'hFF00;
    step(1);
    check(shaper_in_data, 16'hF808);
    wr(13'h008, 8'h40);
    summed_data = 16'h1234;
    step(1);
    check(summed_out_data, 16'h1234);
    wr(13'h008, 8'h80);
    clip_count_clear = 1;
    step(1);
    clip_count_clear = 0;
    summed_data = 16'h4000;
    step(1);
    check({summed_out_data, clip_event}, {16'h7FFF, 1'h1});
    summed_data = 16'hBFFF;
    step(1);
    check({summed_out_data, clip_event}, {16'h8000, 1'h1});
    summed_data = 16'h0000;
    step(1);
    check(clip_event, 1'h0);
    rd(13'h001, 8'h02);
    wr(13'h001, 8'h00);
    rd(13'h001, 8'h02);
    // A clip in the clear cycle must survive the clear
    summed_data = 16'h4000;
    clip_count_clear = 1;
    step(1);
    clip_count_clear = 0;
    summed_data = 16'h0000;
    step(1);
    rd(13'h001, 8'h01);
    summed_data = 16'h4000;
    step(300);
    check(clip_event, 1'h1);
    summed_data = 16'h0000;
    step(1);
    rd(13'h001, 8'hFF);
  endtask : t_datapath
  task automatic t_mid_reset;
    reset = 1;
    step(2);
    reset = 0;
    step(1);
    check(mapper_bypass, 1'h0);
    check(summed_output_gain, 8'h0D);
    check(input_gain, 8'h20);
    check(osc0_tuning_word, 24'h000000);
    rd(13'h001, 8'h00);
  endtask : t_mid_reset
  task automatic t_tuning;
    wr(13'h00A, 8'h11);
    wr(13'h00B, 8'h22);
    wr(13'h00C, 8'h33);
    check(osc0_tuning_word, 24'h332211);
    wr(13'h00B, 8'hAB);
    check(osc0_tuning_word, 24'h33AB11);
    rd(13'h00A, 8'h11);
    wr(13'h109, 8'h00);
    rd(13'h109, 8'h00);
    check(input_gain, 8'hFF);
  endtask : t_tuning
  initial begin
    step(5);
    reset = 0;
    step(1);
    t_reset_values();
    t_bypass();
    t_shape();
    t_datapath();
    t_tuning();
    t_mid_reset();
    test_done();
  end
endmodule : dcr_config_regs_bench
`default_nettype wire
